// ===== isp_dev.sv
// target end: serial slave with register file and clock stretching
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "isp_regs.svh"
module isp_dev
  import isp_pkg::*;
#(
  parameter int WDOG_CYCLES = `ISP_WDOG_US * `ISP_CLK_MHZ
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  isp_if.dev              bus,
  input  wire isp_cur_t   load_current_average,
  input  wire isp_slope_t positioned_voltage_monitor,
  input  wire isp_lvl_t   die_temp_monitor,
  input  wire isp_lvl_t   ext_temp_monitor,
  input  wire logic       target_address_select_pin,
  input  wire logic       loadline_select_high,
  input  wire logic       loadline_select_low,
  output isp_slope_t      active_slope,
  output isp_ofs_t        active_voltage_offset,
  output isp_lvl_t        active_overvolt_level,
  output isp_lvl_t        output_undervolt_level_out,
  output isp_lvl_t        input_undervolt_level_out,
  output logic            overcurrent,
  output logic            die_temp_alert,
  output logic            die_temp_shutdown,
  output logic            ext_temp_alert,
  output logic            ext_temp_shutdown
);
  logic [4:0]  pins;
  logic        scl_f;
  logic        sda_f;
  logic        sel_f;
  logic [1:0]  ll_case;
  logic        prev_scl;
  logic        prev_sda;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  isp_dev_st_t st;
  logic [2:0]  bitcnt;
  logic [2:0]  bytecnt;
  logic [7:0]  sh;
  logic [7:0]  nb;
  logic        rw;
  logic        sda_oe;
  logic        ack_seen;
  logic        lo_sent;
  logic [7:0]  addr_hi;
  logic [7:0]  data_hi;
  logic [15:0] cur_addr;
  logic [15:0] rd_buf;
  logic [15:0] rd_word;
  logic        addr_match;
  logic        byte_done;
  logic        rd_go;
  logic        wr_go;
  logic [16:0] wait_cnt;
  logic        busy;
  isp_slope_t  slope [4];
  isp_ofs_t    offset [4];
  isp_slope_t  oc_slope [4];
  isp_thr_t    oc_thr [4];
  isp_lvl_t    ov_lvl [4];
  isp_lvl_t    die_alert_lvl;
  isp_lvl_t    die_shut_lvl;
  isp_lvl_t    ext_alert_lvl;
  isp_lvl_t    ext_shut_lvl;
  isp_lvl_t    iuv_lvl;
  isp_lvl_t    ouv_lvl;

  // mapped word addresses: live monitors and stored settings
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a <= `ISP_A_OUV) || ((a >= `ISP_A_SLOPE) && (a <= `ISP_A_LAST));
  endfunction

  isp_sync #(.W(5), .INIT(`ISP_DEV_PIN_INIT)) u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   ({bus.scl, bus.sda, target_address_select_pin, loadline_select_high, loadline_select_low}),
    .level (pins)
  );
  assign {scl_f, sda_f, sel_f, ll_case} = pins;

  // open-drain pins: output level fixed low, enables pull
  assign bus.dev_scl_out = 1'b0;
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe  = sda_oe;
  assign bus.dev_scl_oe  = (st == D_ACK) && sda_oe && busy;

  // line event detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
    end else begin
      prev_scl <= scl_f;
      prev_sda <= sda_f;
    end
  end
  assign scl_rise = scl_f && !prev_scl;
  assign scl_fall = !scl_f && prev_scl;
  assign start_c  = scl_f && prev_scl && prev_sda && !sda_f;
  assign stop_c   = scl_f && prev_scl && !prev_sda && sda_f;

  // byte assembly and request decode
  assign nb         = {sh[6:0], sda_f};
  assign addr_match = nb[7:1] == {`ISP_TGT_BASE, sel_f};
  assign byte_done  = (st == D_RX) && scl_rise && (bitcnt == `ISP_BIT_LAST);
  assign rd_go      = byte_done && (bytecnt == 3'h0) && addr_match && nb[0];
  assign wr_go      = byte_done && (bytecnt == `ISP_BYTE_LAST);

  // protocol sequencer, target role only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st       <= D_IDLE;
      bitcnt   <= '0;
      bytecnt  <= '0;
      sh       <= '0;
      rw       <= 1'b0;
      sda_oe   <= 1'b0;
      ack_seen <= 1'b0;
      lo_sent  <= 1'b0;
      addr_hi  <= '0;
      data_hi  <= '0;
      cur_addr <= '0;
    end else if (start_c) begin
      st       <= D_RX;
      bitcnt   <= '0;
      bytecnt  <= '0;
      sda_oe   <= 1'b0;
      ack_seen <= 1'b0;
      lo_sent  <= 1'b0;
    end else if (stop_c) begin
      st     <= D_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (st)
        D_IDLE: begin
        end
        D_RX: if (scl_rise) begin
          sh     <= nb;
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == `ISP_BIT_LAST) begin
            if ((bytecnt == 3'h0) ? addr_match : (bytecnt <= `ISP_BYTE_LAST)) begin
              st      <= D_ACK;
              bytecnt <= bytecnt + 3'h1;
              unique case (bytecnt)
                3'h0: rw <= nb[0];
                3'h1: addr_hi <= nb;
                3'h2: cur_addr <= {addr_hi, nb};
                3'h3: data_hi <= nb;
                default: begin
                end
              endcase
            end else begin
              st <= D_IDLE; // no acknowledge: not ours or overlong
            end
          end
        end
        // first fall drives acknowledge, second fall ends the slot
        D_ACK: if (scl_fall) begin
          if (!sda_oe) begin
            sda_oe <= 1'b1;
          end else if (rw && (bytecnt == 3'h1)) begin
            st     <= D_TX;
            sh     <= rd_buf[15:8];
            sda_oe <= ~rd_buf[15];
            bitcnt <= '0;
          end else begin
            st     <= D_RX;
            sda_oe <= 1'b0;
            bitcnt <= '0;
          end
        end
        // data moves on falling clock while the master leaves the line free
        D_TX: if (scl_fall) begin
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == `ISP_BIT_LAST) begin
            st     <= D_MACK;
            sda_oe <= 1'b0;
          end else begin
            sh     <= {sh[6:0], 1'b0};
            sda_oe <= ~sh[6];
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            if (!sda_f && !lo_sent) begin
              ack_seen <= 1'b1;
            end else begin
              st <= D_IDLE;
            end
          end else if (scl_fall && ack_seen) begin
            st       <= D_TX;
            sh       <= rd_buf[7:0];
            sda_oe   <= ~rd_buf[7];
            bitcnt   <= '0;
            ack_seen <= 1'b0;
            lo_sent  <= 1'b1;
          end
        end
      endcase
    end
  end

  // internal access timer, watchdog length for unmapped words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= '0;
    end else if (rd_go || wr_go) begin
      wait_cnt <= is_mapped(cur_addr) ? 17'(`ISP_ACCESS_CYC) : 17'(WDOG_CYCLES);
    end else if (wait_cnt != 17'h0) begin
      wait_cnt <= wait_cnt - 17'h1;
    end
  end
  assign busy = wait_cnt != 17'h0;

  // read word at the current address, mapped fields zero-extended
  always_comb begin
    rd_word = '0;
    case (cur_addr)
      `ISP_A_CUR_LO:    rd_word = load_current_average[15:0];
      `ISP_A_CUR_HI:    rd_word = 16'(load_current_average[18:16]);
      `ISP_A_VPOS:      rd_word = 16'(positioned_voltage_monitor);
      `ISP_A_DIE_MON:   rd_word = 16'(die_temp_monitor);
      `ISP_A_EXT_MON:   rd_word = 16'(ext_temp_monitor);
      `ISP_A_DIE_ALERT: rd_word = 16'(die_alert_lvl);
      `ISP_A_DIE_SHUT:  rd_word = 16'(die_shut_lvl);
      `ISP_A_EXT_ALERT: rd_word = 16'(ext_alert_lvl);
      `ISP_A_EXT_SHUT:  rd_word = 16'(ext_shut_lvl);
      `ISP_A_IUV:       rd_word = 16'(iuv_lvl);
      `ISP_A_OUV:       rd_word = 16'(ouv_lvl);
      default: begin
        case (cur_addr & `ISP_CASE_MASK)
          `ISP_A_SLOPE:    rd_word = 16'(slope[cur_addr[1:0]]);
          `ISP_A_OFFSET:   rd_word = 16'(offset[cur_addr[1:0]]);
          `ISP_A_OC_SLOPE: rd_word = 16'(oc_slope[cur_addr[1:0]]);
          `ISP_A_OC_THR:   rd_word = 16'(oc_thr[cur_addr[1:0]]);
          `ISP_A_OV:       rd_word = 16'(ov_lvl[cur_addr[1:0]]);
          default:         rd_word = '1; // unmapped reads float high
        endcase
      end
    endcase
  end

  // read word captured when the read control byte completes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_buf <= '0;
    end else if (rd_go) begin
      rd_buf <= rd_word;
    end
  end

  // writable settings; read-only and unmapped words ignore writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slope         <= '{default: '0};
      offset        <= '{default: '0};
      oc_slope      <= '{default: '0};
      oc_thr        <= '{default: '0};
      ov_lvl        <= '{default: '0};
      die_alert_lvl <= '0;
      die_shut_lvl  <= '0;
      ext_alert_lvl <= '0;
      ext_shut_lvl  <= '0;
      iuv_lvl       <= '0;
      ouv_lvl       <= '0;
    end else if (wr_go) begin
      case (cur_addr)
        `ISP_A_DIE_ALERT: die_alert_lvl <= nb[5:0];
        `ISP_A_DIE_SHUT:  die_shut_lvl <= nb[5:0];
        `ISP_A_EXT_ALERT: ext_alert_lvl <= nb[5:0];
        `ISP_A_EXT_SHUT:  ext_shut_lvl <= nb[5:0];
        `ISP_A_IUV:       iuv_lvl <= nb[5:0];
        `ISP_A_OUV:       ouv_lvl <= nb[5:0];
        default: begin
          case (cur_addr & `ISP_CASE_MASK)
            `ISP_A_SLOPE:    slope[cur_addr[1:0]] <= {data_hi[1:0], nb};
            `ISP_A_OFFSET:   offset[cur_addr[1:0]] <= nb[4:0];
            `ISP_A_OC_SLOPE: oc_slope[cur_addr[1:0]] <= {data_hi[1:0], nb};
            `ISP_A_OC_THR:   oc_thr[cur_addr[1:0]] <= nb;
            `ISP_A_OV:       ov_lvl[cur_addr[1:0]] <= nb[5:0];
            default: begin
            end
          endcase
        end
      endcase
    end
  end

  // settings of the selected loadline case and threshold comparisons
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_slope               <= '0;
      active_voltage_offset      <= '0;
      active_overvolt_level      <= '0;
      output_undervolt_level_out <= '0;
      input_undervolt_level_out  <= '0;
      overcurrent                <= 1'b0;
      die_temp_alert             <= 1'b0;
      die_temp_shutdown          <= 1'b0;
      ext_temp_alert             <= 1'b0;
      ext_temp_shutdown          <= 1'b0;
    end else begin
      overcurrent                <= load_current_average > (19'(oc_thr[ll_case]) * 19'(`ISP_OC_STEP_MA));
      active_slope               <= overcurrent ? oc_slope[ll_case] : slope[ll_case];
      active_voltage_offset      <= offset[ll_case];
      active_overvolt_level      <= ov_lvl[ll_case];
      output_undervolt_level_out <= ouv_lvl;
      input_undervolt_level_out  <= iuv_lvl;
      die_temp_alert             <= die_temp_monitor >= die_alert_lvl;
      die_temp_shutdown          <= die_temp_monitor >= die_shut_lvl;
      ext_temp_alert             <= ext_temp_monitor >= ext_alert_lvl;
      ext_temp_shutdown          <= ext_temp_monitor >= ext_shut_lvl;
    end
  end
endmodule

// ===== isp_regs.svh
// register map, pin and timing constants for the serial register port
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH
// target address upper six bits, lsb from the select pin
`define ISP_TGT_BASE     6'h38
// clock and bus timing
`define ISP_CLK_MHZ      100
`define ISP_SCL_KHZ      100
`define ISP_QUARTER_CYC  ((`ISP_CLK_MHZ * 1000) / (`ISP_SCL_KHZ * 4))
`define ISP_ACCESS_NS    200
`define ISP_ACCESS_CYC   ((`ISP_ACCESS_NS * `ISP_CLK_MHZ + 999) / 1000)
`define ISP_WDOG_US      1000
// overcurrent threshold step in mA
`define ISP_OC_STEP_MA   800
// frame counters
`define ISP_BIT_LAST     3'h7
`define ISP_BYTE_LAST    3'h4
`define ISP_ACK_BIT      4'h8
// device word addresses
`define ISP_A_CUR_LO     16'h0000
`define ISP_A_CUR_HI     16'h0001
`define ISP_A_VPOS       16'h0002
`define ISP_A_DIE_MON    16'h0003
`define ISP_A_EXT_MON    16'h0004
`define ISP_A_DIE_ALERT  16'h0005
`define ISP_A_DIE_SHUT   16'h0006
`define ISP_A_EXT_ALERT  16'h0007
`define ISP_A_EXT_SHUT   16'h0008
`define ISP_A_IUV        16'h0009
`define ISP_A_OUV        16'h000a
`define ISP_A_SLOPE      16'h0010
`define ISP_A_OFFSET     16'h0014
`define ISP_A_OC_SLOPE   16'h0018
`define ISP_A_OC_THR     16'h001c
`define ISP_A_OV         16'h0020
`define ISP_A_LAST       16'h0023
`define ISP_CASE_MASK    16'hfffc
// host register offsets and fields
`define ISP_HR_CTRL      4'h0
`define ISP_HR_ADDR      4'h1
`define ISP_HR_WDATA     4'h2
`define ISP_HR_STATUS    4'h3
`define ISP_HR_RDATA     4'h4
`define ISP_CTRL_SEL_BIT 2
// synchroniser reset levels, device {scl,sda,sel,ll_hi,ll_lo}, host {scl,sda}
`define ISP_DEV_PIN_INIT 5'h18
`define ISP_HOST_PIN_INIT 2'h3
`endif

// ===== isp_pkg.sv
// types shared by both ends of the serial register port
package isp_pkg;
  typedef logic [18:0] isp_cur_t;
  typedef logic [9:0]  isp_slope_t;
  typedef logic [7:0]  isp_thr_t;
  typedef logic [5:0]  isp_lvl_t;
  typedef logic [4:0]  isp_ofs_t;
  typedef enum {D_IDLE, D_RX, D_ACK, D_TX, D_MACK} isp_dev_st_t;
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} isp_host_st_t;
  typedef enum logic [1:0] {K_SETADDR, K_WRITE, K_READ} isp_kind_t;
endpackage

// ===== isp_if.sv
// open-drain two-wire link between master and target
`timescale 1ns/10ps
interface isp_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enabled low driver wins
  assign scl = ~((host_scl_oe & ~host_scl_out) | (dev_scl_oe & ~dev_scl_out));
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));
  modport host (output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe, input scl, sda);
  modport dev (output dev_scl_out, dev_scl_oe, dev_sda_out, dev_sda_oe, input scl, sda);
endinterface

// ===== isp_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/10ps
module isp_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] r1;
  logic [W-1:0] r2;
  logic [W-1:0] r3;

  // shift chain plus per-bit agreement filter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r1    <= INIT;
      r2    <= INIT;
      r3    <= INIT;
      level <= INIT;
    end else begin
      r1    <= pin;
      r2    <= r1;
      r3    <= r2;
      level <= (~(r2 ^ r3) & r3) | ((r2 ^ r3) & level);
    end
  end
endmodule

// ===== isp_host.sv
// master end: bit-banged serial master driven by a small register port
`timescale 1ns/10ps
`include "isp_regs.svh"
module isp_host
  import isp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  isp_if.host              bus,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata
);
  logic [1:0]   pins;
  logic         scl_f;
  logic         sda_f;
  isp_host_st_t st;
  isp_kind_t    kind;
  logic         sel;
  logic [15:0]  addr;
  logic [15:0]  wdata;
  logic [15:0]  rdata;
  logic         nack;
  logic [7:0]   qcnt;
  logic         tick;
  logic         stall;
  logic [1:0]   ph;
  logic [3:0]   bitn;
  logic [2:0]   bidx;
  logic [2:0]   last;
  logic         rx;
  logic [7:0]   sh;
  logic         scl_oe;
  logic         sda_oe;

  // byte to send at a given position of the frame; receive slots send all ones
  function automatic logic [7:0] tx_byte(input logic [2:0] i);
    if (kind == K_READ && i != 3'h0) begin
      tx_byte = 8'hff;
    end else begin
      case (i)
        3'h0:    tx_byte = {`ISP_TGT_BASE, sel, kind == K_READ};
        3'h1:    tx_byte = addr[15:8];
        3'h2:    tx_byte = addr[7:0];
        3'h3:    tx_byte = wdata[15:8];
        default: tx_byte = wdata[7:0];
      endcase
    end
  endfunction

  isp_sync #(.W(2), .INIT(`ISP_HOST_PIN_INIT)) u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   ({bus.scl, bus.sda}),
    .level (pins)
  );
  assign {scl_f, sda_f} = pins;

  assign bus.host_scl_out = 1'b0;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_scl_oe  = scl_oe;
  assign bus.host_sda_oe  = sda_oe;

  assign last  = (kind == K_WRITE) ? `ISP_BYTE_LAST : 3'h2;
  assign rx    = (kind == K_READ) && (bidx != 3'h0);
  assign stall = (st != H_IDLE) && !scl_oe && !scl_f; // target stretching the clock
  assign tick  = qcnt == 8'(`ISP_QUARTER_CYC - 1);

  // quarter-bit timer, cleared while the clock line is stretched
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      qcnt <= '0;
    end else if (st == H_IDLE || stall || tick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + 8'h1;
    end
  end

  // command registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kind  <= K_SETADDR;
      sel   <= 1'b0;
      addr  <= '0;
      wdata <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ISP_HR_CTRL: if (st == H_IDLE) begin
          kind <= isp_kind_t'(reg_wdata[1:0]);
          sel  <= reg_wdata[`ISP_CTRL_SEL_BIT];
        end
        `ISP_HR_ADDR:  addr <= reg_wdata;
        `ISP_HR_WDATA: wdata <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // frame sequencer: start, bytes with acknowledge, stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st     <= H_IDLE;
      ph     <= '0;
      bitn   <= '0;
      bidx   <= '0;
      sh     <= '0;
      nack   <= 1'b0;
      rdata  <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (st == H_IDLE) begin
      if (reg_wr && reg_addr == `ISP_HR_CTRL) begin
        st   <= H_START;
        ph   <= '0;
        bidx <= '0;
        nack <= 1'b0;
      end
    end else if (tick) begin
      ph <= ph + 2'h1;
      unique case (st)
        H_START: begin
          if (ph == 2'h0) begin
            sda_oe <= 1'b1;
          end else begin
            scl_oe <= 1'b1;
            ph     <= '0;
            bitn   <= '0;
            sh     <= tx_byte(3'h0);
            st     <= H_BIT;
          end
        end
        H_BIT: begin
          unique case (ph)
            2'h0: sda_oe <= (bitn == `ISP_ACK_BIT) ? (rx && bidx != last) : ~sh[7];
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
              if (bitn != `ISP_ACK_BIT) begin
                sh <= {sh[6:0], sda_f};
              end else if (!rx) begin
                nack <= sda_f;
              end else if (bidx == 3'h1) begin
                rdata[15:8] <= sh;
              end else begin
                rdata[7:0] <= sh;
              end
            end
            2'h3: begin
              scl_oe <= 1'b1;
              bitn   <= bitn + 4'h1;
              if (bitn == `ISP_ACK_BIT) begin
                bitn <= '0;
                if ((!rx && nack) || bidx == last) begin
                  st <= H_STOP;
                end else begin
                  bidx <= bidx + 3'h1;
                  sh   <= tx_byte(bidx + 3'h1);
                end
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (ph)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            2'h3: st <= H_IDLE;
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  // register read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `ISP_HR_CTRL:   reg_rdata <= {13'h0000, sel, kind};
        `ISP_HR_ADDR:   reg_rdata <= addr;
        `ISP_HR_WDATA:  reg_rdata <= wdata;
        `ISP_HR_STATUS: reg_rdata <= {14'h0000, nack, st != H_IDLE};
        `ISP_HR_RDATA:  reg_rdata <= rdata;
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// ===== isp_sva.sv
// link checks for the two-wire port
`timescale 1ns/10ps
module isp_sva #(
  parameter int WDOG = 2000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [31:0] hi_n;
  logic [31:0] st_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // clock-high and stretch run lengths
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_n <= '0;
      st_n <= '0;
    end else begin
      hi_n <= scl ? hi_n + 1 : '0;
      st_n <= dev_scl_oe ? st_n + 1 : '0;
    end
  end
  sequence start_s; scl && $past(scl) && $fell(sda); endsequence
  sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
  sequence quiet_s; (!dev_sda_oe && !dev_scl_oe) [*8]; endsequence
  dev_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("target data moved with clock high");
  start_src_a: assert property (start_s |-> host_sda_oe)
    else $error("start not made by master");
  scl_rate_a: assert property ($rose(host_scl_oe) |-> hi_n >= 240)
    else $error("clock high phase too short");
  stretch_ack_a: assert property (dev_scl_oe |-> dev_sda_oe)
    else $error("stretch outside ack slot");
  stretch_low_a: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("stretch cut a high phase");
  wdog_cap_a: assert property (st_n <= WDOG)
    else $error("stretch beyond watchdog");
  bus_free_a: assert property ($fell(dev_scl_oe) |-> !dev_scl_oe [*8])
    else $error("clock taken again after release");
  stop_quiet_a: assert property (stop_s |-> quiet_s)
    else $error("target drives after stop");
endmodule

// ===== tb.sv
// bench: host register port drives frames into the target end
`timescale 1ns/10ps
`include "isp_regs.svh"
module tb import isp_pkg::*;;
  logic        clk, nrst, reg_wr, reg_rd, note, note_d, rd_d;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, last, d;
  logic [31:0] seed, mon;
  logic [1:0]  ll;
  isp_ofs_t    ofs;
  logic [15:0] exp_q[$];
  int          failures = 0;
  int          n_checks = 0;
  isp_if bus();
  isp_host isp_host_i (.clk(clk), .nrst(nrst), .bus(bus.host), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  isp_dev #(.WDOG_CYCLES(2000)) isp_dev_i (.clk(clk), .nrst(nrst), .bus(bus.dev),
    .load_current_average(mon[18:0]), .positioned_voltage_monitor(mon[9:0]),
    .die_temp_monitor(mon[5:0]), .ext_temp_monitor(mon[11:6]), .target_address_select_pin(1'b0),
    .loadline_select_high(ll[1]), .loadline_select_low(ll[0]), .active_slope(),
    .active_voltage_offset(ofs), .active_overvolt_level(), .output_undervolt_level_out(),
    .input_undervolt_level_out(), .overcurrent(), .die_temp_alert(), .die_temp_shutdown(),
    .ext_temp_alert(), .ext_temp_shutdown());
  isp_sva #(.WDOG(2000)) isp_sva_i (.clk(clk), .nrst(nrst), .host_scl_oe(bus.host_scl_oe),
    .host_sda_oe(bus.host_sda_oe), .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe),
    .scl(bus.scl), .sda(bus.sda));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one strobe cycle, then one idle cycle
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v, input logic n);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    note <= n;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    note <= 1'b0;
    @(posedge clk);
  endtask
  // load address and data, start a frame, poll until idle
  task automatic frame(input logic [15:0] a, input logic [15:0] v, input logic [2:0] c);
    int i;
    acc(1'b1, `ISP_HR_ADDR, a, 1'b0);
    acc(1'b1, `ISP_HR_WDATA, v, 1'b0);
    acc(1'b1, `ISP_HR_CTRL, {13'h0000, c}, 1'b0);
    for (i = 0; i < 30000; i++) begin
      acc(1'b0, `ISP_HR_STATUS, 16'h0000, 1'b0);
      if (reg_rdata[0] === 1'b0) break; // read data still stands at this edge
    end
    @(posedge clk); // let the watcher take the final status into last
    if (i == 30000) begin
      failures++;
      results();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // result watcher: keeps read data, compares noted reads
  always @(posedge clk) begin
    rd_d <= reg_rd;
    note_d <= note;
    if (rd_d) last <= reg_rdata;
    if (note_d) chk(reg_rdata, exp_q.pop_front());
  end
  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, note, rd_d, note_d} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    last = 16'h0000;
    seed = xs(32'h0000_483b);
    mon = seed;
    ll = seed[21:20];
    d = {11'h000, seed[28:24]};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    // wrong target address is refused
    frame(16'h0000, 16'h0000, 3'h4);
    chk(last, 16'h0002);
    // write the offset of the selected case
    frame(`ISP_A_OFFSET + {14'h0000, ll}, d, 3'h1);
    chk(last, 16'h0000);
    chk({11'h000, ofs}, d);
    // read back from the kept address
    frame(16'h0000, 16'h0000, 3'h2);
    exp_q.push_back(d);
    acc(1'b0, `ISP_HR_RDATA, 16'h0000, 1'b1);
    // unmapped write stretches, then frees the bus
    frame(16'h0030, 16'hffff, 3'h1);
    chk(last, 16'h0000);
    chk({11'h000, ofs}, d);
    results();
  end
endmodule
